//--- include/scpf_cfg.svh
// How it works
// - Secondary code 111 divides 1, 000 divides 8
// - Primary codes 11,10,01,00 divide 1,4,16,64
// - Edge select ignored while framed mode on
// - Framed enable bit turns framed operation on
// - Direction set means sync input, clear output
// - Polarity set means active high sync pulse
// - Edge bit set: sync coincides first clock
// - Buffer bit picks enhanced or legacy buffering
`ifndef SCPF_CFG_SVH
`define SCPF_CFG_SVH
`define SCPF_CTL1_OFS 32'h0000_0000
`define SCPF_CTL2_OFS 32'h0000_0004
`define SCPF_STAT_OFS 32'h0000_0008
`define SCPF_CTL1_RST 16'h0000
`define SCPF_CTL2_RST 16'h0000
`define SCPF_CTL1_MASK 16'h1FFF
`define SCPF_CTL2_MASK 16'hE003
`define SCPF_PPRE_LSB 0
`define SCPF_SPRE_LSB 2
`define SCPF_MSTEN_BIT 5
`define SCPF_CKP_BIT 6
`define SCPF_CKE_BIT 8
`define SCPF_FRAMED_MODE_ENABLE_BIT 15
`define SCPF_FSD_BIT 14
`define SCPF_FPOL_BIT 13
`define SCPF_FE_BIT 1
`define SCPF_BEN_BIT 0
`define SCPF_RESP_OKAY 2'b00
`define SCPF_RESP_SLVERR 2'b10
`endif

//--- include/scpf_pkg.sv
`default_nettype none
package scpf_pkg;
  typedef struct packed {
    logic fr_en;
    logic fs_in;
    logic fs_hi;
    logic fs_coin;
    logic buf_en;
    logic edge_sel;
  } scpf_mode_t;
endpackage
`default_nettype wire

//--- logic/scpf_top.sv
`include "scpf_cfg.svh"
`default_nettype none
module scpf_top (
  input wire logic I_SYS_CLK,
  input wire logic I_NRST,
  input wire logic [31:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [31:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic O_SCK_TICK,
  output logic O_SCK,
  output logic O_FRAMED,
  output logic O_FS_OE_N,
  output logic O_FS_COIN,
  output logic O_FS_ACT_HI,
  output logic O_EDGE_SEL,
  output logic O_BUF_EN
);
  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [15:0] ctl1_r;
  logic [15:0] ctl2_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [31:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic fs_oe_n_r;
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s, input logic [15:0] m);
    logic [15:0] n;
    n = old;
    if (s[0]) n[7:0] = d[7:0];
    if (s[1]) n[15:8] = d[15:8];
    merge16 = n & m;
  endfunction
  // Only the low address byte is decoded, so registers alias every 256 bytes
  function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] ofs);
    addr_hit = a[7:0] == ofs[7:0];
  endfunction
  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire aw_take = I_AWVALID && !aw_hold_r && !bvalid_r;
  wire w_take = I_WVALID && !w_hold_r && !bvalid_r;
  wire do_wr = aw_hold_r && w_hold_r && !bvalid_r;
  // Status is read only, so a write to it answers with an error
  wire wr_c1 = do_wr && addr_hit(awaddr_r, `SCPF_CTL1_OFS);
  wire wr_c2 = do_wr && addr_hit(awaddr_r, `SCPF_CTL2_OFS);
  wire wr_ok = wr_c1 || wr_c2;
  wire [15:0] ctl1_nxt = merge16(ctl1_r, wdata_r, wstrb_r, `SCPF_CTL1_MASK);
  wire [15:0] ctl2_nxt = merge16(ctl2_r, wdata_r, wstrb_r, `SCPF_CTL2_MASK);
  wire ar_take = I_ARVALID && !arready_r && !rvalid_r;
  wire rd_hit1 = addr_hit(I_ARADDR, `SCPF_CTL1_OFS);
  wire rd_hit2 = addr_hit(I_ARADDR, `SCPF_CTL2_OFS);
  wire rd_hit3 = addr_hit(I_ARADDR, `SCPF_STAT_OFS);
  wire rd_ok = rd_hit1 || rd_hit2 || rd_hit3;
  // ---------------------------------------------------------------
  // Prescaler
  // ---------------------------------------------------------------
  logic [1:0] ppre;
  logic [2:0] spre;
  logic [5:0] pri_cnt_r;
  logic [2:0] sec_cnt_r;
  logic [5:0] pri_max;
  logic [2:0] sec_max;
  logic sck_r;
  logic tick_r;
  assign ppre = ctl1_r[`SCPF_PPRE_LSB +: 2];
  assign spre = ctl1_r[`SCPF_SPRE_LSB +: 3];
  // Both stages at one-to-one are not blocked; software must avoid that pair
  assign pri_max = (ppre == 2'b11) ? 6'h00 : (ppre == 2'b10) ? 6'h03 :
                   (ppre == 2'b01) ? 6'h0F : 6'h3F;
  assign sec_max = 3'h7 - spre;
  wire mst = ctl1_r[`SCPF_MSTEN_BIT];
  wire pri_end = pri_cnt_r == pri_max;
  wire sec_end = sec_cnt_r == sec_max;
  wire tick = mst && pri_end && sec_end;
  wire [15:0] stat = {14'h0000, sck_r, mst};
  wire [15:0] rd_word = rd_hit1 ? ctl1_r : rd_hit2 ? ctl2_r : rd_hit3 ? stat : 16'h0000;
  scpf_pkg::scpf_mode_t mode;
  assign mode.fr_en = ctl2_r[`SCPF_FRAMED_MODE_ENABLE_BIT];
  assign mode.fs_in = ctl2_r[`SCPF_FSD_BIT];
  assign mode.fs_hi = ctl2_r[`SCPF_FPOL_BIT];
  assign mode.fs_coin = ctl2_r[`SCPF_FE_BIT];
  assign mode.buf_en = ctl2_r[`SCPF_BEN_BIT];
  assign mode.edge_sel = ctl1_r[`SCPF_CKE_BIT] && !mode.fr_en;
  // ---------------------------------------------------------------
  // Write channel
  // ---------------------------------------------------------------
  // Address and data may land in either order; the response waits for both
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_NRST) begin
      aw_hold_r <= 1'b0;
      awaddr_r <= 32'h0000_0000;
    end else if (aw_take) begin
      aw_hold_r <= 1'b1;
      awaddr_r <= I_AWADDR;
    end else if (do_wr) begin
      aw_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_NRST) begin
      w_hold_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (w_take) begin
      w_hold_r <= 1'b1;
      wdata_r <= I_WDATA;
      wstrb_r <= I_WSTRB;
    end else if (do_wr) begin
      w_hold_r <= 1'b0;
    end
  end

  // Response holds until the master takes it
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_NRST) begin
      bvalid_r <= 1'b0;
      bresp_r <= 2'b00;
    end else if (do_wr) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_ok ? `SCPF_RESP_OKAY : `SCPF_RESP_SLVERR;
    end else if (bvalid_r && I_BREADY) begin
      bvalid_r <= 1'b0;
    end
  end
  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  // Drive enable takes the new value, so it never lags the framed flag
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_NRST) begin
      ctl1_r <= `SCPF_CTL1_RST;
      ctl2_r <= `SCPF_CTL2_RST;
      fs_oe_n_r <= 1'b1;
    end else begin
      if (wr_c1) ctl1_r <= ctl1_nxt;
      if (wr_c2) begin
        ctl2_r <= ctl2_nxt;
        fs_oe_n_r <= !ctl2_nxt[`SCPF_FRAMED_MODE_ENABLE_BIT] || ctl2_nxt[`SCPF_FSD_BIT];
      end
    end
  end
  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  // Read data is frozen at acceptance and stands until the master takes it
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_NRST) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= 2'b00;
    end else begin
      arready_r <= ar_take;
      if (ar_take) begin
        rvalid_r <= 1'b1;
        rresp_r <= rd_ok ? `SCPF_RESP_OKAY : `SCPF_RESP_SLVERR;
        rdata_r <= {16'h0000, rd_word};
      end else if (rvalid_r && I_RREADY) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Prescaler counters
  // ---------------------------------------------------------------
  // Counters restart when master mode drops so the first period is whole
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_NRST || !mst) begin
      pri_cnt_r <= 6'h00;
      sec_cnt_r <= 3'h0;
      sck_r <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      pri_cnt_r <= pri_end ? 6'h00 : pri_cnt_r + 6'h01;
      if (pri_end) sec_cnt_r <= sec_end ? 3'h0 : sec_cnt_r + 3'h1;
      tick_r <= tick;
      // Pin toggles per tick, so its period is two ticks
      if (tick) sck_r <= ~sck_r;
    end
  end
  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign O_AWREADY = aw_hold_r;
  assign O_WREADY = w_hold_r;
  assign O_BVALID = bvalid_r;
  assign O_BRESP = bresp_r;
  assign O_ARREADY = arready_r;
  assign O_RVALID = rvalid_r;
  assign O_RDATA = rdata_r;
  assign O_RRESP = rresp_r;
  assign O_SCK_TICK = tick_r;
  assign O_SCK = sck_r;
  assign O_FRAMED = ctl2_r[`SCPF_FRAMED_MODE_ENABLE_BIT];
  assign O_FS_OE_N = fs_oe_n_r;
  assign O_FS_ACT_HI = ctl2_r[`SCPF_FPOL_BIT];
  assign O_FS_COIN = ctl2_r[`SCPF_FE_BIT];
  assign O_BUF_EN = ctl2_r[`SCPF_BEN_BIT];
  // ---------------------------------------------------------------
  // Edge select
  // ---------------------------------------------------------------
  // Registered so the pin comes from a flop; framed mode masks it
  logic edge_sel_r;
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_NRST) edge_sel_r <= 1'b0;
    else edge_sel_r <= mode.edge_sel;
  end
  assign O_EDGE_SEL = edge_sel_r;
endmodule
`default_nettype wire

//--- sim/scpf_props_properties.sv
`include "scpf_cfg.svh"
`default_nettype none
// ----------
// Checker
// ----------
module scpf_props (
  input wire logic I_SYS_CLK,
  input wire logic I_NRST,
  input wire logic I_BREADY,
  input wire logic I_RREADY,
  input wire logic O_BVALID,
  input wire logic O_RVALID,
  input wire logic O_ARREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic [1:0] O_RRESP,
  input wire logic O_SCK_TICK,
  input wire logic O_SCK,
  input wire logic O_FRAMED,
  input wire logic O_FS_OE_N,
  input wire logic O_EDGE_SEL
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_NRST);
  sequence rd_wait;
    O_RVALID && !I_RREADY;
  endsequence
  chk_rd_hold: assert property (rd_wait |=> O_RVALID && $stable(O_RDATA))
    else $error("read answer dropped");
  chk_wr_hold: assert property (O_BVALID && !I_BREADY |=> O_BVALID)
    else $error("write answer dropped");
  chk_ar_answer: assert property (O_ARREADY |-> O_RVALID)
    else $error("read taken without answer");
  chk_unmap_zero: assert property (O_RVALID && O_RRESP == `SCPF_RESP_SLVERR |-> O_RDATA == 0)
    else $error("unmapped read not zero");
  chk_sync_drive: assert property (!O_FS_OE_N |-> O_FRAMED)
    else $error("sync driven outside framed mode");
  chk_edge_ignored: assert property (O_FRAMED |=> !O_EDGE_SEL)
    else $error("edge select live in framed mode");
  chk_sck_toggle: assert property (O_SCK_TICK |-> ##[0:1] $changed(O_SCK))
    else $error("serial clock missed a tick");
  // Reset itself is the cause here, so it cannot disable the check
  chk_rst_idle: assert property (disable iff (1'b0) !I_NRST |=> O_FS_OE_N && !O_FRAMED)
    else $error("outputs not idle in reset");
endmodule
bind scpf_top scpf_props u_props (.*);
`default_nettype wire

//--- sim/scpf_link_dev.sv
`default_nettype none
// ----------
// Far side
// ----------
module scpf_link_dev (
  input wire logic i_sck,
  output int o_edges
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_edges = 0;
  // Counts every level change so a missing toggle shows
  always @(i_sck) o_edges <= o_edges + 1;
endmodule
`default_nettype wire

//--- sim/testbench.sv
`include "scpf_cfg.svh"
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
  err_total++; $display("wrong value %0t mismatch", $time); end end
// ----------
// Bench
// ----------
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic I_SYS_CLK, I_NRST, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY;
  logic [31:0] I_AWADDR, I_WDATA, I_ARADDR, O_RDATA;
  logic [3:0] I_WSTRB;
  logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_SCK_TICK, O_SCK;
  logic O_FRAMED, O_FS_OE_N, O_FS_COIN, O_FS_ACT_HI, O_EDGE_SEL, O_BUF_EN;
  logic [1:0] O_BRESP, O_RRESP;
  int err_total, checks_done, edges, n, e0;
  scpf_top DUT (.*);
  scpf_link_dev u_dev (.i_sck(O_SCK), .o_edges(edges));
  initial begin
    I_SYS_CLK = 1'h0;
    forever #10 I_SYS_CLK = ~I_SYS_CLK;
  end
  task wr(input logic [31:0] a, input logic [31:0] d);
    I_AWADDR <= a;
    I_WDATA <= d;
    {I_AWVALID, I_WVALID, I_BREADY} <= 3'h7;
    do begin
      @(posedge I_SYS_CLK);
      if (O_AWREADY) I_AWVALID <= 1'h0;
      if (O_WREADY) I_WVALID <= 1'h0;
    end while (!O_BVALID);
    `CHK(O_BRESP, `SCPF_RESP_OKAY)
    I_BREADY <= 1'h0;
    @(posedge I_SYS_CLK);
  endtask
  task rc(input logic [31:0] a, input logic [31:0] e, input logic [1:0] r);
    I_ARADDR <= a;
    {I_ARVALID, I_RREADY} <= 2'h3;
    do begin
      @(posedge I_SYS_CLK);
      if (O_ARREADY) I_ARVALID <= 1'h0;
    end while (!O_RVALID);
    `CHK({O_RRESP, O_RDATA}, {r, e})
    I_RREADY <= 1'h0;
    @(posedge I_SYS_CLK);
  endtask
  task per(input int p, input int s);
    wr(`SCPF_CTL1_OFS, 32'h0000_0020 | (s << 2) | p);
    do @(posedge I_SYS_CLK); while (!O_SCK_TICK);
    n = 0;
    e0 = edges;
    do begin
      @(posedge I_SYS_CLK);
      n++;
    end while (!O_SCK_TICK);
    `CHK(n, (8 - s) << (6 - 2 * p))
    `CHK(edges - e0, 1)
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    {I_NRST, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY} = 6'h00;
    {I_AWADDR, I_WDATA, I_ARADDR} = 96'h0;
    I_WSTRB = 4'hF;
    repeat (3) @(posedge I_SYS_CLK);
    I_NRST <= 1'h1;
    @(posedge I_SYS_CLK);
    rc(`SCPF_CTL1_OFS, 32'h0000_0000, `SCPF_RESP_OKAY);
    rc(`SCPF_CTL2_OFS, 32'h0000_0000, `SCPF_RESP_OKAY);
    rc(32'h0000_0010, 32'h0000_0000, `SCPF_RESP_SLVERR);
    `CHK(O_FS_OE_N, 1'h1)
    $display("reset test done");
    wr(`SCPF_CTL2_OFS, 32'h0000_FFFF);
    rc(`SCPF_CTL2_OFS, 32'h0000_E003, `SCPF_RESP_OKAY);
    `CHK({O_FRAMED, O_FS_OE_N, O_FS_ACT_HI, O_FS_COIN, O_BUF_EN}, 5'h1F)
    wr(`SCPF_CTL2_OFS, 32'h0000_8000);
    `CHK({O_FRAMED, O_FS_OE_N, O_FS_ACT_HI, O_FS_COIN, O_BUF_EN}, 5'h10)
    $display("frame test done");
    wr(`SCPF_CTL2_OFS, 32'h0000_0000);
    wr(`SCPF_CTL1_OFS, 32'h0000_0100);
    `CHK(O_EDGE_SEL, 1'h1)
    wr(`SCPF_CTL2_OFS, 32'h0000_8000);
    `CHK(O_EDGE_SEL, 1'h0)
    $display("edge test done");
    // Both dividers at one-to-one is left out on purpose
    for (int p = 0; p < 4; p++) for (int s = 0; s < 8; s++) if (p != 3 || s != 7) per(p, s);
    $display("rate test done");
    finish_test;
  end
  initial begin
    #1000000;
    err_total++;
    finish_test;
  end
endmodule
`default_nettype wire
